// File: hdl/vic_pkg.sv
// constants, register map and carrier types of the vectored irq controller
// assumes a simple synchronous register port of the host core
package vic_pkg;
    localparam int NUM_CH = 32;
    localparam int NUM_FAST = 3;
    localparam int PRIO_W = 4;
    localparam int CH_W = 5;
    localparam int STACK_DEPTH = 16;
    localparam int SP_W = 4;

    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CUR_CHANNEL = 8'h04;
    localparam logic [7:0] OFS_CUR_PRIO = 8'h08;
    localparam logic [7:0] OFS_VECTOR = 8'h18;
    localparam logic [7:0] OFS_FAST_ENABLE = 8'h1C;
    localparam logic [7:0] OFS_ENABLE = 8'h20;
    localparam logic [7:0] OFS_FAST_PENDING = 8'h3C;
    localparam logic [7:0] OFS_PENDING = 8'h40;
    localparam logic [7:0] OFS_SOURCE_BASE = 8'h60;
    localparam logic [7:0] OFS_SOURCE_LAST = 8'hDC;

    localparam int CTRL_NORMAL_BIT = 0;
    localparam int CTRL_FAST_BIT = 1;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 4'h0;
    localparam logic [CH_W-1:0] CH_RESET = 5'h00;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } vic_req_s;

    typedef struct packed {
        logic [PRIO_W-1:0] prio;
        logic [CH_W-1:0] ch;
    } vic_frame_s;
endpackage

// File: hdl/vic_stack_mem.sv
// nesting stack storage of saved priority and channel frames
// assumes a single clock; read data is registered
`timescale 1ns/1ns
module vic_stack_mem
    import vic_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int AW = SP_W
) (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire vic_frame_s wrData,
    input wire logic [AW-1:0] rdAddr,
    output vic_frame_s rdData
);
    vic_frame_s mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// File: hdl/vic_controller.sv
// vectored nested interrupt controller core with register port
// assumes request lines are asynchronous and a one-cycle read port
`timescale 1ns/1ns
module vic_controller
    import vic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire vic_req_s busReq,
    output logic [31:0] busRdata,
    input wire logic [NUM_CH-1:0] irqIn,
    input wire logic [NUM_FAST-1:0] fastIn,
    output logic irqOut_n,
    output logic fastOut_n
);
    // ======================================================
    // state
    typedef struct packed {
        logic [NUM_CH-1:0] sync1;
        logic [NUM_CH-1:0] sync2;
        logic [NUM_FAST-1:0] fsync1;
        logic [NUM_FAST-1:0] fsync2;
        logic [1:0] ctrl;
        logic [NUM_CH-1:0] enable;
        logic [NUM_FAST-1:0] fastEnable;
        logic [NUM_CH-1:0] pending;
        logic [NUM_FAST-1:0] fastPending;
        logic [15:0] vecHigh;
        logic [15:0] vecLow;
        logic [PRIO_W-1:0] curPrio;
        logic [CH_W-1:0] curCh;
        logic [PRIO_W-1:0] basePrio;
        logic [SP_W:0] sp;
        logic hold;
        logic popWait;
        logic winValid;
        logic [CH_W-1:0] winCh;
        logic [PRIO_W-1:0] winPrio;
        logic [31:0] rdata;
        logic irqN;
        logic fastN;
    } vic_state_s;

    vic_state_s st_r;
    vic_state_s st_nxt;
    logic [PRIO_W-1:0] prioTab [NUM_CH];
    logic [15:0] vecTab [NUM_CH];
    vic_frame_s stackRd;
    logic pushEn;
    logic [SP_W-1:0] stackWrAddr;
    logic [SP_W-1:0] stackRdAddr;
    vic_frame_s pushFrame;

    // ======================================================
    // helpers
    function automatic logic srcHit(input logic [7:0] a, output logic [CH_W-1:0] idx);
        logic [7:0] rel;
        rel = a - OFS_SOURCE_BASE;
        idx = rel[CH_W+1:2];
        return (a >= OFS_SOURCE_BASE) && (a <= OFS_SOURCE_LAST) && (rel[1:0] == 2'b00);
    endfunction

    // ======================================================
    // source entry table: vector low half and priority
    logic srcWr;
    logic [CH_W-1:0] srcIdx;
    always_comb begin
        srcWr = 1'b0;
        srcIdx = '0;
        if (busReq.sel && busReq.wr) begin
            srcWr = srcHit(busReq.addr, srcIdx);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                prioTab[i] <= PRIO_RESET;
                vecTab[i] <= 16'h0000;
            end
        end else if (srcWr) begin
            vecTab[srcIdx] <= busReq.wdata[31:16];
            prioTab[srcIdx] <= busReq.wdata[PRIO_W-1:0];
        end
    end

    // ======================================================
    // stack memory
    vic_stack_mem #(
        .DEPTH(STACK_DEPTH),
        .AW(SP_W)
    ) uStack (
        .clk(clk),
        .wrEn(pushEn),
        .wrAddr(stackWrAddr),
        .wrData(pushFrame),
        .rdAddr(stackRdAddr),
        .rdData(stackRd)
    );

    // ======================================================
    // next state
    always_comb begin
        logic [NUM_CH-1:0] cand;
        logic [NUM_CH-1:0] clrMask;
        logic [NUM_FAST-1:0] fclrMask;
        logic found;
        logic [PRIO_W-1:0] bestP;
        logic [CH_W-1:0] bestC;
        logic vecRead;
        logic eoi;
        logic [CH_W-1:0] idx;
        logic hit;
        st_nxt = st_r;
        cand = '0;
        clrMask = '0;
        fclrMask = '0;
        found = 1'b0;
        bestP = '0;
        bestC = '0;
        idx = '0;
        hit = 1'b0;
        pushEn = 1'b0;
        pushFrame = '{prio: st_r.curPrio, ch: st_r.curCh};
        stackWrAddr = st_r.sp[SP_W-1:0];
        stackRdAddr = st_r.sp[SP_W-1:0] - 4'h1;

        st_nxt.sync1 = irqIn;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.fsync1 = fastIn;
        st_nxt.fsync2 = st_r.fsync1;

        vecRead = busReq.sel && !busReq.wr && busReq.addr == OFS_VECTOR;
        if (busReq.sel && busReq.wr) begin
            case (busReq.addr)
                OFS_CONTROL: st_nxt.ctrl = busReq.wdata[1:0];
                OFS_VECTOR: st_nxt.vecHigh = busReq.wdata[31:16];
                OFS_ENABLE: st_nxt.enable = busReq.wdata;
                OFS_FAST_ENABLE: st_nxt.fastEnable = busReq.wdata[NUM_FAST-1:0];
                OFS_PENDING: clrMask = busReq.wdata;
                OFS_FAST_PENDING: fclrMask = busReq.wdata[NUM_FAST-1:0];
                OFS_CUR_PRIO: begin
                    if (busReq.wdata[PRIO_W-1:0] >= st_r.basePrio) begin
                        st_nxt.curPrio = busReq.wdata[PRIO_W-1:0];
                    end
                end
                default: ;
            endcase
        end

        // set wins over clear
        st_nxt.pending = (st_r.pending & ~clrMask) | st_r.sync2;
        st_nxt.fastPending = (st_r.fastPending & ~fclrMask) | st_r.fsync2;

        // arbitration, ascending index so later equal wins
        cand = st_r.pending & st_r.enable;
        for (int i = 0; i < NUM_CH; i++) begin
            if (cand[i] && prioTab[i] > st_r.curPrio && (!found || prioTab[i] >= bestP)) begin
                found = 1'b1;
                bestP = prioTab[i];
                bestC = CH_W'(i);
            end
        end
        st_nxt.winValid = found && !st_r.hold;
        st_nxt.winCh = bestC;
        st_nxt.winPrio = bestP;
        if (found && !st_r.hold) begin
            st_nxt.vecLow = vecTab[bestC];
        end
        st_nxt.hold = 1'b0;

        eoi = st_r.sp != '0 && clrMask[st_r.curCh] && !st_r.popWait;
        if (vecRead && st_r.winValid) begin
            pushEn = 1'b1;
            st_nxt.sp = st_r.sp + 5'd1;
            st_nxt.curPrio = st_r.winPrio;
            st_nxt.curCh = st_r.winCh;
            st_nxt.basePrio = st_r.winPrio;
            st_nxt.hold = 1'b1;
            st_nxt.winValid = 1'b0;
        end else if (eoi) begin
            st_nxt.popWait = 1'b1;
            st_nxt.hold = 1'b1;
            st_nxt.winValid = 1'b0;
        end else if (st_r.popWait) begin
            st_nxt.popWait = 1'b0;
            st_nxt.sp = st_r.sp - 5'd1;
            st_nxt.curPrio = stackRd.prio;
            st_nxt.curCh = stackRd.ch;
            st_nxt.hold = 1'b1;
            st_nxt.winValid = 1'b0;
        end
        if (st_r.popWait) begin
            st_nxt.basePrio = stackRd.prio;
        end

        st_nxt.irqN = !(st_nxt.winValid && st_r.ctrl[CTRL_NORMAL_BIT]);
        st_nxt.fastN = !(|(st_r.fastPending & st_r.fastEnable)
                         && st_r.ctrl[CTRL_FAST_BIT]);

        st_nxt.rdata = 32'h0000_0000;
        if (busReq.sel && !busReq.wr) begin
            case (busReq.addr)
                OFS_CONTROL: st_nxt.rdata = {30'h0, st_r.ctrl};
                OFS_CUR_CHANNEL: st_nxt.rdata = {27'h0, st_r.curCh};
                OFS_CUR_PRIO: st_nxt.rdata = {28'h0, st_r.curPrio};
                OFS_VECTOR: st_nxt.rdata = {st_r.vecHigh, st_r.vecLow};
                OFS_ENABLE: st_nxt.rdata = st_r.enable;
                OFS_FAST_ENABLE: st_nxt.rdata = {29'h0, st_r.fastEnable};
                OFS_PENDING: st_nxt.rdata = st_r.pending;
                OFS_FAST_PENDING: st_nxt.rdata = {29'h0, st_r.fastPending};
                default: begin
                    hit = srcHit(busReq.addr, idx);
                    if (hit) begin
                        st_nxt.rdata = {vecTab[idx], 12'h000, prioTab[idx]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.irqN <= 1'b1;
            st_r.fastN <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busRdata = st_r.rdata;
    assign irqOut_n = st_r.irqN;
    assign fastOut_n = st_r.fastN;
endmodule

// File: test/vic_controller_props.sv
// assertions on the controller register port and request outputs
// assumes it is bound onto the controller top
`timescale 1ns/1ns
module vic_controller_props
    import vic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire vic_req_s busReq,
    input wire logic [31:0] busRdata,
    input wire logic [NUM_CH-1:0] irqIn,
    input wire logic [NUM_FAST-1:0] fastIn,
    input wire logic irqOut_n,
    input wire logic fastOut_n
);
    // ====
    // helpers
    logic [15:0] vecHi_r;
    logic rd;
    logic wrt;
    assign rd = busReq.sel && !busReq.wr;
    assign wrt = busReq.sel && busReq.wr;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vecHi_r <= 16'h0000;
        end else if (wrt && busReq.addr == OFS_VECTOR) begin
            vecHi_r <= busReq.wdata[31:16];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ====
    // properties
    vec_read_drop_a: assert property (
        rd && busReq.addr == OFS_VECTOR |=> irqOut_n) else $error("request kept after fetch");
    vec_high_a: assert property (
        rd && busReq.addr == OFS_VECTOR |=> busRdata[31:16] == vecHi_r)
        else $error("vector high half wrong");
    unmapped_zero_a: assert property (
        rd && busReq.addr == 8'hF0 |=> busRdata == 32'h0000_0000) else $error("unmapped not zero");
    ctrl_rsvd_a: assert property (
        rd && busReq.addr == OFS_CONTROL |=> busRdata[31:2] == 30'h0) else $error("control rsvd");
    chan_rsvd_a: assert property (
        rd && busReq.addr == OFS_CUR_CHANNEL |=> busRdata[31:5] == 27'h0) else $error("chan rsvd");
    prio_rsvd_a: assert property (
        rd && busReq.addr == OFS_CUR_PRIO |=> busRdata[31:4] == 28'h0) else $error("prio rsvd");
    irq_mask_a: assert property (
        wrt && busReq.addr == OFS_CONTROL && !busReq.wdata[CTRL_NORMAL_BIT] |-> ##2 irqOut_n)
        else $error("normal request not masked");
    fast_mask_a: assert property (
        wrt && busReq.addr == OFS_CONTROL && !busReq.wdata[CTRL_FAST_BIT] |-> ##2 fastOut_n)
        else $error("fast request not masked");
    cover property (rd && busReq.addr == OFS_VECTOR && !irqOut_n);
    cover property ($fell(fastOut_n));
    cover property ($rose(irqOut_n));
endmodule

// File: test/vic_core_model.sv
// core side: samples the active-low request lines
// assumes the bench performs the vector fetch on the register port
`timescale 1ns/1ns
module vic_core_model (
    input wire logic clk,
    input wire logic irqOut_n,
    input wire logic fastOut_n,
    output logic irqSeen,
    output logic fastSeen
);
    always_ff @(posedge clk) begin
        irqSeen <= !irqOut_n;
        fastSeen <= !fastOut_n;
    end
endmodule

// File: test/vic_controller_tb.sv
// self-checking bench of the controller with a core model
// assumes a 10 MHz clock and the register map of the package
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
$display("Error %0t: got %h want %h", $time, a, b); end end
module vic_controller_tb
    import vic_pkg::*;
;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    vic_req_s busReq = '0;
    logic [31:0] irqIn = 32'h0;
    logic [2:0] fastIn = 3'h0;
    logic [31:0] busRdata;
    logic irqOut_n;
    logic fastOut_n;
    logic irqSeen;
    logic fastSeen;
    int err_count = 0;
    int cmp_count = 0;
    always #50 clk = ~clk;
    vic_controller uut (.clk(clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata),
        .irqIn(irqIn), .fastIn(fastIn), .irqOut_n(irqOut_n), .fastOut_n(fastOut_n));
    vic_core_model u_core (.clk(clk), .irqOut_n(irqOut_n), .fastOut_n(fastOut_n),
        .irqSeen(irqSeen), .fastSeen(fastSeen));
    // ====
    // bus and wait helpers
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        busReq <= '{1'h1, w, a, d};
        @(posedge clk);
        busReq.sel <= 1'h0;
        #1 q = busRdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'h1, a, d, q);
    endtask
    task automatic ck(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'h0, a, 32'h0, q);
        `CHK(q, e)
    endtask
    task automatic src(input int n, input logic [15:0] v, input logic [3:0] p);
        wr(OFS_SOURCE_BASE + 8'(4 * n), {v, 12'h000, p});
    endtask
    task automatic wt(input logic f, input logic v);
        int i;
        i = 0;
        while (i < 30 && (f ? fastSeen : irqSeen) !== v) begin
            @(posedge clk);
            #1 i++;
        end
        if ((f ? fastSeen : irqSeen) !== v) begin
            err_count++;
            $display("Error %0t: request line wait timed out", $time);
            test_done();
        end
        cmp_count++;
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ====
    // scenarios
    task automatic s_reset();
        ck(OFS_CONTROL, 32'h0);
        ck(OFS_CUR_PRIO, 32'h0);
        ck(OFS_CUR_CHANNEL, 32'h0);
        ck(8'hF0, 32'h0);
    endtask
    task automatic s_arb();
        wr(OFS_VECTOR, 32'hABCD_0000);
        src(2, 16'h0002, 4'h5);
        src(6, 16'h0006, 4'h5);
        src(9, 16'h0009, 4'h5);
        src(10, 16'h000A, 4'h7);
        src(20, 16'h0014, 4'h0);
        wr(OFS_ENABLE, 32'h0010_0644);
        wr(OFS_CONTROL, 32'h1);
        @(posedge clk) irqIn <= 32'h0010_0044;
        wt(1'h0, 1'h1);
        ck(OFS_VECTOR, 32'hABCD_0006);
        ck(OFS_CUR_PRIO, 32'h5);
        ck(OFS_CUR_CHANNEL, 32'h6);
        ck(OFS_PENDING, 32'h0010_0044);
        wt(1'h0, 1'h0);
    endtask
    task automatic s_nest();
        @(posedge clk) irqIn <= 32'h0010_0644;
        wt(1'h0, 1'h1);
        ck(OFS_VECTOR, 32'hABCD_000A);
        ck(OFS_CUR_CHANNEL, 32'hA);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_CUR_PRIO, 32'h3);
        ck(OFS_CUR_PRIO, 32'h7);
        wr(OFS_CUR_PRIO, 32'h9);
        ck(OFS_CUR_PRIO, 32'h9);
        wr(OFS_CUR_PRIO, 32'h7);
        ck(OFS_CUR_PRIO, 32'h7);
        wr(OFS_CONTROL, 32'h1);
    endtask
    task automatic s_eoi();
        @(posedge clk) irqIn <= 32'h0010_0244;
        // let the dropped line pass the synchroniser, else set beats clear
        repeat (3) @(posedge clk);
        wr(OFS_PENDING, 32'h0000_0400);
        repeat (2) @(posedge clk);
        ck(OFS_CUR_PRIO, 32'h5);
        ck(OFS_CUR_CHANNEL, 32'h6);
        wr(OFS_PENDING, 32'h0);
        ck(OFS_PENDING, 32'h0010_0244);
        @(posedge clk) irqIn <= 32'h0010_0204;
        repeat (3) @(posedge clk);
        wr(OFS_PENDING, 32'h0000_0040);
        wr(OFS_CONTROL, 32'h0);
        wt(1'h0, 1'h0);
        wr(OFS_CONTROL, 32'h1);
        wt(1'h0, 1'h1);
        ck(OFS_VECTOR, 32'hABCD_0009);
    endtask
    task automatic s_fast();
        wr(OFS_FAST_ENABLE, 32'h2);
        wr(OFS_CONTROL, 32'h3);
        @(posedge clk) fastIn <= 3'h1;
        repeat (8) @(posedge clk);
        `CHK(fastSeen, 1'h0)
        @(posedge clk) fastIn <= 3'h3;
        wt(1'h1, 1'h1);
        wr(OFS_CONTROL, 32'h1);
        wt(1'h1, 1'h0);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        s_reset();
        s_arb();
        s_nest();
        s_eoi();
        s_fast();
        test_done();
    end
endmodule
bind vic_controller vic_controller_props u_props (.clk(clk), .rst_n(rst_n), .busReq(busReq),
    .busRdata(busRdata), .irqIn(irqIn), .fastIn(fastIn), .irqOut_n(irqOut_n),
    .fastOut_n(fastOut_n));
